// >>> rss_hold_timer.sv
module rss_hold_timer
	import rss_pkg::*;
#(
	parameter int CW = CNT_W,
	parameter longint unsigned DEF_CYC = HOLD_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Control.
	input wire logic start,
	input wire logic useExt,
	input wire logic [CW-1:0] extCount,
	// Result.
	output logic done,
	output logic busy
);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic run_r, run_nxt;
	logic [CW-1:0] loadLen;
	logic [CW-1:0] elapsed_r;
	logic [CW-1:0] loaded_r;

	assign done = run_r && (cnt_r == '0);
	assign busy = run_r;

	always_comb begin
		loadLen = CW'(DEF_CYC);
		if (useExt) begin
			loadLen = (extCount == '0) ? CW'(1) : extCount;
		end
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		if (start) begin
			cnt_nxt = loadLen - CW'(1);
			run_nxt = 1'b1;
		end else if (run_r) begin
			if (cnt_r == '0) begin
				run_nxt = 1'b0;
			end else begin
				cnt_nxt = cnt_r - CW'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
		end
	end

	// Helper logic: cycles seen since the last start, and the length loaded then.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			elapsed_r <= '0;
			loaded_r <= '0;
		end else if (ce) begin
			elapsed_r <= start ? '0 : elapsed_r + CW'(1);
			loaded_r <= start ? loadLen : loaded_r;
		end
	end

	chk_hold_length: assert property (@(posedge clk) disable iff (rst)
		ce && done |-> elapsed_r == loaded_r - CW'(1))
		else $error("hold timer ended after the wrong number of cycles");
endmodule

// >>> rss_pkg.sv
package rss_pkg;
	// Clock and time base.
	localparam int CNT_W = 33;
	localparam longint unsigned CLK_HZ = 100_000_000;
	localparam longint unsigned HOLD_TIME_MS = 140;
	localparam longint unsigned WD_TIMEOUT_MS = 1600;
	localparam longint unsigned WD_STARTUP_S = 54;
	localparam longint unsigned HOLD_CYC = (HOLD_TIME_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned WD_CYC = (WD_TIMEOUT_MS * CLK_HZ + 999) / 1000;
	localparam longint unsigned WD_START_CYC = WD_STARTUP_S * CLK_HZ;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_HOLD_COUNT = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;

	// Control field positions.
	localparam int CTRL_BAND = 0;
	localparam int CTRL_MARGIN = 1;
	localparam int CTRL_TIMEOUT_SET = 2;
	localparam int CTRL_SEP_FAULT = 3;
	localparam int CTRL_PER_RAIL = 4;
	localparam int CTRL_W = 5;

	// Status field positions.
	localparam int STAT_RESET = 0;
	localparam int STAT_FAULT = 1;
	localparam int STAT_ARMED = 2;
	localparam int STAT_STATE = 3;
	localparam int STAT_RAILS = 8;

	// Interrupt status and mask bits.
	localparam int IRQ_RESET = 0;
	localparam int IRQ_WATCHDOG = 1;
	localparam int IRQ_RAIL = 2;
	localparam int IRQ_W = 3;

	// Values after reset.
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam logic [31:0] HOLD_COUNT_RST = 32'h0000_1388;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	typedef enum logic [2:0] {
		ST_ASSERT = 3'b001,
		ST_HOLD = 3'b010,
		ST_RUN = 3'b100
	} rss_state_e;
endpackage

// >>> rss_proc_model.sv
module rss_proc_model (
	// Clock and control.
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	// Kick pin.
	output logic kick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	// Kicks every 16 cycles, well inside the shortened timeout.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			kick <= 1'b0;
		end else if (en) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == 4'hf) kick <= ~kick;
		end
	end
endmodule

// >>> rss_supervisor.sv
// What this block does
// - Outside margin test, reset is asserted while any rail is below threshold or manual reset is requested.
// - Once all rails are good and manual reset is released, reset stays for the full hold time.
// - The hold time is 140 ms by default or a software count when the timeout select is set.
// - An unserviced watchdog asserts reset, or the separate fault flag on that variant.
// - A floating kick input disables the watchdog entirely.
// - After reset ends the first watchdog interval is 54 s, except on the separate-flag variant.
// - Margin test holds reset, the watchdog fault flag and the rail flags deasserted whatever the rails do.
// - The band select picks the 5% or 10% comparator result for all rails.
// - Each rail has its own fail flag that follows only that rail.
// - Outside margin test, reset is released only when every rail is present.
module rss_supervisor
	import rss_pkg::*;
#(
	parameter int RAILS = 8,
	parameter longint unsigned HOLD_CYCLES = HOLD_CYC,
	parameter longint unsigned WD_CYCLES = WD_CYC,
	parameter longint unsigned WD_START_CYCLES = WD_START_CYC
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Rail comparators and supervisory inputs.
	input wire logic [RAILS-1:0] railBelow5,
	input wire logic [RAILS-1:0] railBelow10,
	input wire logic manualResetRequest,
	input wire logic watchdogKickPin,
	input wire logic watchdogKickFloating,
	// Supervisory outputs.
	output logic resetOut,
	output logic watchdogFaultFlag,
	output logic [RAILS-1:0] railFailFlag,
	output logic irq
);
	function automatic logic isReg(input logic [31:0] addr, input logic [7:0] off);
		isReg = (addr[7:0] == off) && (addr[31:8] == '0);
	endfunction

	// Bus and register state.
	logic addrPhase;
	logic wrPend_r, wrPend_nxt;
	logic [31:0] wrAddr_r, wrAddr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [31:0] holdCount_r, holdCount_nxt;
	logic [IRQ_W-1:0] irqStat_r, irqStat_nxt;
	logic [IRQ_W-1:0] irqMask_r, irqMask_nxt;
	logic [31:0] statusWord;
	logic [IRQ_W-1:0] irqEvents;
	logic statClear;

	// Sequencer state.
	rss_state_e state_r, state_nxt;
	logic resetOut_r, resetOut_nxt;
	logic fault_r, fault_nxt;
	logic [RAILS-1:0] railFlag_r, railFlag_nxt;
	logic kickPrev_r;
	logic anyFail_r;
	logic [RAILS-1:0] railFail;
	logic anyFail;
	logic condition;
	logic margin;
	logic separate;
	logic kickEdge;
	logic holdStart;
	logic holdDone;
	logic wdExpire;

	rss_wd_if wdBus();

	assign margin = ctrl_r[CTRL_MARGIN];
	assign separate = ctrl_r[CTRL_SEP_FAULT];

	// Rail selection per band.
	generate
		for (genvar i = 0; i < RAILS; i++) begin : g_rail
			assign railFail[i] = ctrl_r[CTRL_BAND] ? railBelow10[i] : railBelow5[i];
		end
	endgenerate

	assign anyFail = |railFail;
	assign condition = anyFail || manualResetRequest;
	assign kickEdge = watchdogKickPin ^ kickPrev_r;

	// Sequencer next state.
	always_comb begin
		state_nxt = state_r;
		holdStart = 1'b0;
		case (state_r)
			ST_ASSERT: begin
				if (!condition) begin
					state_nxt = ST_HOLD;
					holdStart = 1'b1;
				end
			end
			ST_HOLD: begin
				if (condition) begin
					state_nxt = ST_ASSERT;
				end else if (holdDone) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (condition) begin
					state_nxt = ST_ASSERT;
				end else if (wdExpire && !separate) begin
					state_nxt = ST_HOLD;
					holdStart = 1'b1;
				end
			end
			default: begin
				state_nxt = ST_ASSERT;
			end
		endcase
		resetOut_nxt = (state_nxt != ST_RUN) && !margin;
		fault_nxt = separate && !margin && (fault_r || wdExpire) && (wdExpire || !kickEdge);
		for (int i = 0; i < RAILS; i++) begin
			railFlag_nxt[i] = railFail[i] && ctrl_r[CTRL_PER_RAIL] && !margin;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_ASSERT;
			resetOut_r <= 1'b1;
			fault_r <= 1'b0;
			railFlag_r <= '0;
			kickPrev_r <= 1'b0;
			anyFail_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			resetOut_r <= resetOut_nxt;
			fault_r <= fault_nxt;
			railFlag_r <= railFlag_nxt;
			kickPrev_r <= watchdogKickPin;
			anyFail_r <= anyFail;
		end
	end

	assign resetOut = resetOut_r;
	assign watchdogFaultFlag = fault_r;
	assign railFailFlag = railFlag_r;

	rss_hold_timer #(
		.CW(CNT_W),
		.DEF_CYC(HOLD_CYCLES)
	) u_hold (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.start(holdStart),
		.useExt(ctrl_r[CTRL_TIMEOUT_SET]),
		.extCount({1'b0, holdCount_r}),
		.done(holdDone),
		.busy()
	);

	// Watchdog runs only outside reset and only when the kick pin is driven.
	assign wdBus.arm = (state_r == ST_RUN) && !watchdogKickFloating;
	assign wdBus.startup = !separate;
	assign wdBus.kick = kickEdge;
	assign wdExpire = wdBus.expire;

	rss_watchdog #(
		.CW(CNT_W),
		.TIMEOUT_CYC(WD_CYCLES),
		.START_CYC(WD_START_CYCLES)
	) u_wd (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.wd(wdBus.dog)
	);

	// Register bus: zero wait states, frozen while the clock enable is low.
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign addrPhase = hsel && hready && htrans[1] && ce;
	assign statClear = addrPhase && !hwrite && isReg(haddr, OFF_IRQ_STAT);
	assign irqEvents[IRQ_RESET] = resetOut_nxt && !resetOut_r;
	assign irqEvents[IRQ_WATCHDOG] = wdExpire;
	assign irqEvents[IRQ_RAIL] = anyFail && !anyFail_r;
	assign irq = |(irqStat_r & irqMask_r);

	always_comb begin
		statusWord = '0;
		statusWord[STAT_RESET] = resetOut_r;
		statusWord[STAT_FAULT] = fault_r;
		statusWord[STAT_ARMED] = wdBus.arm;
		statusWord[STAT_STATE +: 3] = state_r;
		statusWord[STAT_RAILS +: RAILS] = railFail;
	end

	always_comb begin
		wrPend_nxt = addrPhase && hwrite;
		wrAddr_nxt = addrPhase ? haddr : wrAddr_r;
		hrdata_nxt = hrdata_r;
		ctrl_nxt = ctrl_r;
		holdCount_nxt = holdCount_r;
		irqMask_nxt = irqMask_r;
		if (addrPhase && !hwrite) begin
			hrdata_nxt = '0;
			if (isReg(haddr, OFF_CTRL)) begin
				hrdata_nxt[CTRL_W-1:0] = ctrl_r;
			end
			if (isReg(haddr, OFF_HOLD_COUNT)) begin
				hrdata_nxt = holdCount_r;
			end
			if (isReg(haddr, OFF_STATUS)) begin
				hrdata_nxt = statusWord;
			end
			if (isReg(haddr, OFF_IRQ_STAT)) begin
				hrdata_nxt[IRQ_W-1:0] = irqStat_r;
			end
			if (isReg(haddr, OFF_IRQ_MASK)) begin
				hrdata_nxt[IRQ_W-1:0] = irqMask_r;
			end
		end
		if (wrPend_r) begin
			if (isReg(wrAddr_r, OFF_CTRL)) begin
				ctrl_nxt = hwdata[CTRL_W-1:0];
			end
			if (isReg(wrAddr_r, OFF_HOLD_COUNT)) begin
				holdCount_nxt = hwdata;
			end
			if (isReg(wrAddr_r, OFF_IRQ_MASK)) begin
				irqMask_nxt = hwdata[IRQ_W-1:0];
			end
		end
		// A new event in the clearing cycle survives the clear.
		irqStat_nxt = (statClear ? IRQ_RST : irqStat_r) | irqEvents;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= '0;
			hrdata_r <= '0;
			ctrl_r <= CTRL_RST;
			holdCount_r <= HOLD_COUNT_RST;
			irqStat_r <= IRQ_RST;
			irqMask_r <= IRQ_RST;
		end else if (ce) begin
			wrPend_r <= wrPend_nxt;
			wrAddr_r <= wrAddr_nxt;
			hrdata_r <= hrdata_nxt;
			ctrl_r <= ctrl_nxt;
			holdCount_r <= holdCount_nxt;
			irqStat_r <= irqStat_nxt;
			irqMask_r <= irqMask_nxt;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_fail_forces_reset: assert property (
		ce && condition && !margin |=> resetOut_r)
		else $error("reset not asserted for a failing rail or manual request");
	chk_release_after_hold: assert property (
		ce && state_r == ST_HOLD && state_nxt == ST_RUN |-> holdDone && !condition)
		else $error("reset released before the hold time ended");
	chk_release_all_good: assert property (
		$fell(resetOut_r) && !$past(margin) |-> $past(railFail) == '0)
		else $error("reset released while a rail was failing");
	chk_wd_resets: assert property (
		ce && wdExpire && !separate && !condition |=> state_r == ST_HOLD && resetOut_r != margin)
		else $error("watchdog expiry did not start a reset");
	chk_wd_fault_flag: assert property (
		ce && wdExpire && separate && !margin |=> watchdogFaultFlag && state_r != ST_HOLD)
		else $error("separate watchdog flag not raised");
	chk_wd_disabled: assert property (
		watchdogKickFloating |-> !wdExpire && !wdBus.arm)
		else $error("watchdog active with a floating kick input");
	chk_margin_quiet: assert property (
		ce && margin |=> !resetOut_r && railFailFlag == '0 && !watchdogFaultFlag)
		else $error("outputs asserted during margin test");
	chk_rail_flags: assert property (
		ce && ctrl_r[CTRL_PER_RAIL] && !margin |=> railFailFlag == $past(railFail))
		else $error("rail flag does not follow its own rail");
	chk_band_select: assert property (
		ctrl_r[CTRL_BAND] |-> railFail == railBelow10)
		else $error("10 percent band not selected");
	chk_wd_hold_then_startup: assert property (
		ce && state_r == ST_HOLD && holdDone && !condition |=>
			state_r == ST_RUN && (watchdogKickFloating || $rose(wdBus.arm)))
		else $error("watchdog reset did not end into a fresh startup interval");

	cov_release: cover property ($fell(resetOut_r));
	cov_wd_reset: cover property (wdExpire && !separate);
	cov_wd_flag: cover property ($rose(watchdogFaultFlag));
	cov_margin: cover property ($rose(margin) && condition);
endmodule

// >>> rss_watchdog.sv
module rss_watchdog
	import rss_pkg::*;
#(
	parameter int CW = CNT_W,
	parameter longint unsigned TIMEOUT_CYC = WD_CYC,
	parameter longint unsigned START_CYC = WD_START_CYC
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Link to the sequencer.
	rss_wd_if.dog wd
);
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic armPrev_r;

	// Expiry is a one-cycle pulse; a kick in the same cycle wins.
	assign wd.expire = wd.arm && armPrev_r && (cnt_r == '0) && !wd.kick;

	always_comb begin
		cnt_nxt = cnt_r;
		if (!wd.arm) begin
			cnt_nxt = '0;
		end else if (!armPrev_r) begin
			cnt_nxt = wd.startup ? CW'(START_CYC - 1) : CW'(TIMEOUT_CYC - 1);
		end else if (wd.kick || cnt_r == '0) begin
			cnt_nxt = CW'(TIMEOUT_CYC - 1);
		end else begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			armPrev_r <= 1'b0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
			armPrev_r <= wd.arm;
		end
	end

	chk_startup_load: assert property (@(posedge clk) disable iff (rst)
		ce && wd.arm && !armPrev_r && wd.startup |=> cnt_r == CW'(START_CYC - 1))
		else $error("startup interval not loaded on arming");
	chk_kick_restart: assert property (@(posedge clk) disable iff (rst)
		ce && wd.arm && armPrev_r && wd.kick |=> cnt_r == CW'(TIMEOUT_CYC - 1))
		else $error("kick did not restart the watchdog");
endmodule

// >>> rss_wd_if.sv
interface rss_wd_if;
	logic arm;
	logic startup;
	logic kick;
	logic expire;

	modport host (output arm, output startup, output kick, input expire);
	modport dog (input arm, input startup, input kick, output expire);
endinterface

// >>> tb_multi_rail_reset_supervisor.sv
module tb_multi_rail_reset_supervisor
	import rss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int HC = 20;
	localparam int WC = 50;
	localparam int SC = 200;
	logic clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp, irq;
	logic mrr, kick, kickEn, floatK, resetOut, wdFault;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [7:0] below5, below10, railFail;
	int errCount = 0;
	int testsRun = 0;
	int n;
	assign hready = hreadyout;
	rss_supervisor #(.HOLD_CYCLES(HC), .WD_CYCLES(WC), .WD_START_CYCLES(SC)) dut (
		.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .railBelow5(below5),
		.railBelow10(below10), .manualResetRequest(mrr), .watchdogKickPin(kick),
		.watchdogKickFloating(floatK), .resetOut(resetOut),
		.watchdogFaultFlag(wdFault), .railFailFlag(railFail), .irq(irq));
	rss_proc_model proc (.clk(clk), .rst(rst), .en(kickEn), .kick(kick));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chkIn(input int v, input int lo, input int hi, input string m);
		testsRun++;
		if (v < lo || v > hi) begin
			errCount++;
			$display("wrong value at %0t: %s %0d", $time, m, v);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		chk(x, e, m);
	endtask
	// Counts edges until the selected output reaches the level, bounded.
	task automatic waitFor(input logic wd, input logic lvl, output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1;
			c++;
		end while ((wd ? wdFault : resetOut) !== lvl && c < 1000);
	endtask
	task automatic pulseManual(input int len);
		@(posedge clk);
		mrr <= 1'b1;
		@(posedge clk);
		#1;
		chk(resetOut, 1'b1, "manual reset not seen");
		repeat (len) @(posedge clk);
		mrr <= 1'b0;
		waitFor(1'b0, 1'b0, n);
	endtask
	task automatic testRegs;
		rdChk(OFF_STATUS, 32'h24, "status after release");
		chk(hresp, 1'b0, "bus response not okay");
		rdChk(OFF_CTRL, 32'h0, "ctrl reset");
		rdChk(OFF_HOLD_COUNT, HOLD_COUNT_RST, "hold count reset");
		rdChk(OFF_IRQ_MASK, 32'h0, "mask reset");
		rdChk(8'h40, 32'h0, "unmapped read");
		wr(OFF_HOLD_COUNT, 32'h7);
		rdChk(OFF_HOLD_COUNT, 32'h7, "hold count write");
	endtask
	task automatic testHold;
		wr(OFF_CTRL, 32'h04);
		pulseManual(3);
		chk(n, 7 + 1, "external hold length");
		wr(OFF_CTRL, 32'h00);
		pulseManual(3);
		chk(n, HC + 1, "default hold length");
	endtask
	task automatic testRails;
		wr(OFF_CTRL, 32'h10);
		below5 <= 8'h08;
		below10 <= 8'h20;
		repeat (3) @(posedge clk);
		#1;
		chk({resetOut, railFail}, 9'h108, "5% band flags");
		wr(OFF_CTRL, 32'h11);
		repeat (2) @(posedge clk);
		#1;
		chk({resetOut, railFail}, 9'h120, "10% band flags");
		below10 <= 8'h00;
		waitFor(1'b0, 1'b0, n);
		chk(n, HC + 1, "release when all present");
		chk(railFail, 8'h00, "flags clear when all present");
		below5 <= 8'h00;
	endtask
	task automatic testMargin;
		wr(OFF_CTRL, 32'h12);
		below5 <= 8'hff;
		repeat (4) @(posedge clk);
		#1;
		chk({resetOut, wdFault, railFail}, 10'h0, "margin outputs");
		below5 <= 8'h00;
		wr(OFF_CTRL, 32'h00);
		waitFor(1'b0, 1'b0, n);
	endtask
	task automatic testWatchdog;
		int hi;
		hi = 0;
		repeat (400) begin
			@(posedge clk);
			hi = hi | resetOut;
		end
		chk(hi, 0, "kicked watchdog fired");
		rdChk(OFF_IRQ_STAT, 32'h5, "sticky reset and rail events");
		wr(OFF_IRQ_MASK, 32'h2);
		pulseManual(2);
		kickEn <= 1'b0;
		waitFor(1'b0, 1'b1, n);
		chkIn(n, SC - 5, SC + 5, "startup interval");
		chk(irq, 1'b1, "irq on expiry");
		waitFor(1'b0, 1'b0, n);
		chkIn(n, HC - 1, HC + 3, "watchdog reset length");
		rdChk(OFF_IRQ_STAT, 32'h3, "expiry and reset events");
		chk(irq, 1'b0, "irq after clear");
		waitFor(1'b0, 1'b1, n);
		chkIn(n, SC - 5, SC + 5, "restart with startup");
		floatK <= 1'b1;
		waitFor(1'b0, 1'b0, n);
		waitFor(1'b0, 1'b1, n);
		chk(n, 1000, "floating kick disables");
	endtask
	task automatic testSeparate;
		floatK <= 1'b0;
		wr(OFF_CTRL, 32'h08);
		pulseManual(2);
		waitFor(1'b1, 1'b1, n);
		chkIn(n, WC - 5, WC + 5, "no startup on fault variant");
		chk(resetOut, 1'b0, "fault variant keeps reset");
		kickEn <= 1'b1;
		waitFor(1'b1, 1'b0, n);
		chkIn(n, 1, 20, "kick clears fault");
	endtask
	task automatic printVerdict;
		if (errCount == 0 && testsRun > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#60000;
		errCount++;
		printVerdict();
	end
	initial begin
		{rst, ce, kickEn} = 3'b111;
		{hsel, hwrite, mrr, floatK, htrans} = 6'h0;
		{haddr, hwdata, below5, below10} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		waitFor(1'b0, 1'b0, n);
		chk(n, HC + 1, "hold after power-on");
		testRegs();
		testHold();
		testRails();
		testMargin();
		testWatchdog();
		testSeparate();
		printVerdict();
	end
endmodule
